// ### verilog/tpsram.sv
// Two-port 256 x 9 SRAM with parity generate or check and two read modes
//
// Contract
// - Write side timed by its own clock
// - Read side timed by its own clock
// - Nine-bit data, bit 8 carries parity
// - Parity odd select: high odd, low even
// - Read parity error flags bad read data in check mode only
// - Write parity error flags bad write data in check mode only
// - Transparent mode: outputs update same read cycle
// - Pipelined mode: outputs after second read edge
// - Same-address collision passes write data out
// - Write at read edge gives new data
`timescale 1ns/1ps
`include "tpsram_map.svh"
module tpsram (
    // Clock and reset
    input  wire logic                        i_clk_sys,
    input  wire logic                        i_rst,
    // Write port pins
    input  wire logic                        i_write_clock_in,
    input  wire logic [`TPSRAM_ADDR_W-1:0]   i_write_addr_bus,
    input  wire logic                        i_write_block_sel_n,
    input  wire logic                        i_write_strobe_n,
    input  wire logic [`TPSRAM_DATA_W-1:0]   i_write_data_in,
    // Read port pins
    input  wire logic                        i_read_clock_in,
    input  wire logic [`TPSRAM_ADDR_W-1:0]   i_read_addr_bus,
    input  wire logic                        i_read_block_sel_n,
    input  wire logic                        i_read_strobe_n,
    // Configuration
    input  wire logic                        i_parity_odd_sel,
    input  wire logic                        i_parity_generate,
    input  wire logic                        i_read_pipelined,
    // Read results and write parity error flag
    output logic      [`TPSRAM_DATA_W-1:0]   o_read_data_out,
    output logic                             o_read_parity_err,
    output logic                             o_write_parity_err
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation

    localparam logic [`TPSRAM_SYNC_W-1:0] SYNC_RST =
        {2'h0, 4'hF, 3'h0, 25'h0};

    logic [`TPSRAM_SYNC_W-1:0] sync_q;
    logic                      wclk;
    logic                      rclk;
    logic                      w_blk_n;
    logic                      w_stb_n;
    logic                      r_blk_n;
    logic                      r_stb_n;
    logic                      par_odd;
    tpsram_pkg::tpsram_pmode_t pmode;
    tpsram_pkg::tpsram_rmode_t rmode;
    logic [`TPSRAM_ADDR_W-1:0] w_addr;
    logic [`TPSRAM_ADDR_W-1:0] r_addr;
    logic [`TPSRAM_DATA_W-1:0] w_data;

    tpsram_sync #(
        .W       (`TPSRAM_SYNC_W),
        .RST_VAL (SYNC_RST)
    ) i_tpsram_sync (
        .i_clk_sys (i_clk_sys),
        .i_rst     (i_rst),
        .i_d       ({i_write_clock_in, i_read_clock_in,
                     i_write_block_sel_n, i_write_strobe_n,
                     i_read_block_sel_n, i_read_strobe_n,
                     i_parity_odd_sel, i_parity_generate, i_read_pipelined,
                     i_write_addr_bus, i_read_addr_bus, i_write_data_in}),
        .o_q       (sync_q)
    );

    assign {wclk, rclk, w_blk_n, w_stb_n, r_blk_n, r_stb_n, par_odd} = sync_q[33:27];
    assign pmode  = tpsram_pkg::tpsram_pmode_t'(sync_q[26]);
    assign rmode  = tpsram_pkg::tpsram_rmode_t'(sync_q[25]);
    assign w_addr = sync_q[24:17];
    assign r_addr = sync_q[16:9];
    assign w_data = sync_q[8:0];

    ////////////////////////////////////////////////////////////////////////////
    // Edge detection and port enables

    logic wclk_d;
    logic rclk_d;
    logic wr_edge;
    logic rd_edge;
    logic wr_fire;
    logic rd_fire;
    logic collide;

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            wclk_d <= 1'b0;
            rclk_d <= 1'b0;
        end else begin
            wclk_d <= wclk;
            rclk_d <= rclk;
        end
    end

    assign wr_edge = wclk & ~wclk_d;
    assign rd_edge = rclk & ~rclk_d;
    assign wr_fire = wr_edge & ~w_blk_n & ~w_stb_n;
    assign rd_fire = rd_edge & ~r_blk_n & ~r_stb_n;
    // Write seen at the same sampled instant counts as before the read edge
    assign collide = rd_fire & wr_fire & (w_addr == r_addr);

    ////////////////////////////////////////////////////////////////////////////
    // Parity

    // Bit 8 value that makes the word's parity match the odd/even choice
    function automatic logic par_of(input logic [7:0] d, input logic odd);
        par_of = (^d) ^ odd;
    endfunction

    logic [`TPSRAM_DATA_W-1:0] w_word;

    always_comb begin
        w_word = w_data;
        if (pmode == tpsram_pkg::TPSRAM_PARITY_GENERATE) begin
            w_word[`TPSRAM_PAR_BIT] = par_of(w_data[7:0], par_odd);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Storage; contents have no reset, as in the array itself

    logic [`TPSRAM_DATA_W-1:0] mem [`TPSRAM_DEPTH];

    always_ff @(posedge i_clk_sys) begin
        if (wr_fire) begin
            mem[w_addr] <= w_word;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_write_parity_err <= 1'b0;
        end else if (wr_fire) begin
            o_write_parity_err <= (pmode == tpsram_pkg::TPSRAM_PARITY_CHECK) &&
                (w_data[`TPSRAM_PAR_BIT] != par_of(w_data[7:0], par_odd));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    logic [`TPSRAM_DATA_W-1:0] rd_word;
    logic                      rd_err;
    logic [`TPSRAM_DATA_W-1:0] stage_data;
    logic                      stage_err;

    assign rd_word = collide ? w_word : mem[r_addr];
    assign rd_err  = (pmode == tpsram_pkg::TPSRAM_PARITY_CHECK) &&
                     (rd_word[`TPSRAM_PAR_BIT] != par_of(rd_word[7:0], par_odd));

    // Pipeline stage catches the access at its first read edge
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            stage_data <= '0;
            stage_err  <= 1'b0;
        end else if (rd_fire) begin
            stage_data <= rd_word;
            stage_err  <= rd_err;
        end
    end

    // Single output register, so the pins always come from a flop
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_read_data_out   <= '0;
            o_read_parity_err <= 1'b0;
        end else begin
            unique case (rmode)
                tpsram_pkg::TPSRAM_READ_TRANSPARENT: begin
                    if (rd_fire) begin
                        o_read_data_out   <= rd_word;
                        o_read_parity_err <= rd_err;
                    end
                end
                tpsram_pkg::TPSRAM_READ_PIPELINED: begin
                    if (rd_edge) begin
                        o_read_data_out   <= stage_data;
                        o_read_parity_err <= stage_err;
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    a_write_stores: assert property (
        wr_fire |=> mem[$past(w_addr)] == $past(w_word))
        else $error("write not stored");

    a_write_blocked: assert property (
        wr_edge && (w_blk_n || w_stb_n) |-> !wr_fire)
        else $error("write taken while deselected");

    a_gen_parity: assert property (
        wr_fire && pmode == tpsram_pkg::TPSRAM_PARITY_GENERATE
        |=> mem[$past(w_addr)][8] == ((^$past(w_data[7:0])) ^ $past(par_odd)))
        else $error("generated parity bit wrong");

    a_wpe_flag: assert property (
        wr_fire |=> o_write_parity_err == ($past(pmode) == tpsram_pkg::TPSRAM_PARITY_CHECK &&
            ($past(w_data[8]) != ((^$past(w_data[7:0])) ^ $past(par_odd)))))
        else $error("write parity error flag wrong");

    a_trans_read: assert property (
        rd_fire && !collide && rmode == tpsram_pkg::TPSRAM_READ_TRANSPARENT
        |=> o_read_data_out == $past(mem[r_addr]))
        else $error("transparent read data wrong");

    a_collide_pass: assert property (
        collide && rmode == tpsram_pkg::TPSRAM_READ_TRANSPARENT
        |=> o_read_data_out == $past(w_word))
        else $error("collision did not pass write data");

    a_pipe_delay: assert property (
        rd_edge && rmode == tpsram_pkg::TPSRAM_READ_PIPELINED
        |=> o_read_data_out == $past(stage_data) &&
            o_read_parity_err == $past(stage_err))
        else $error("pipelined output not from stage");

    a_rpe_gen_quiet: assert property (
        rd_fire && pmode == tpsram_pkg::TPSRAM_PARITY_GENERATE &&
        rmode == tpsram_pkg::TPSRAM_READ_TRANSPARENT |=> !o_read_parity_err)
        else $error("read parity error in generate mode");

    a_read_idle: assert property (
        !rd_edge |=> $stable(o_read_data_out))
        else $error("read output moved without read edge");

endmodule

// ### shared/tpsram_map.svh
// Constants for the two-port parity SRAM block
`ifndef TPSRAM_MAP_SVH
`define TPSRAM_MAP_SVH

`define TPSRAM_ADDR_W  8
`define TPSRAM_DATA_W  9
`define TPSRAM_DEPTH   256
`define TPSRAM_PAR_BIT 8
`define TPSRAM_SYNC_W  34

`endif

// ### shared/tpsram_pkg.sv
// Types for the two-port parity SRAM block
package tpsram_pkg;

    typedef enum logic [0:0] {
        TPSRAM_READ_TRANSPARENT = 1'b0,
        TPSRAM_READ_PIPELINED   = 1'b1
    } tpsram_rmode_t;

    typedef enum logic [0:0] {
        TPSRAM_PARITY_CHECK    = 1'b0,
        TPSRAM_PARITY_GENERATE = 1'b1
    } tpsram_pmode_t;

endpackage

// ### verilog/tpsram_sync.sv
// Two-flop synchroniser for a bus of independent pin levels
`timescale 1ns/1ps
module tpsram_sync #(
    parameter int         W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic         i_clk_sys,
    input  wire logic         i_rst,
    // Levels
    input  wire logic [W-1:0] i_d,
    output logic      [W-1:0] o_q
);

    logic [W-1:0] meta;

    // Meta stage feeds only the second stage
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            meta <= RST_VAL;
            o_q  <= RST_VAL;
        end else begin
            meta <= i_d;
            o_q  <= meta;
        end
    end

endmodule

// ### bench/tpsram_user.sv
// Fabric-side user logic model that drives the memory block's pins
`timescale 1ns/1ps
module tpsram_user (
    // Clock
    input  wire logic       i_clk_sys,
    // Write side pins
    output logic            o_wclk,
    output logic [7:0]      o_write_addr_bus,
    output logic            o_wsel_n,
    output logic            o_wstb_n,
    output logic [8:0]      o_wdata,
    // Read side pins
    output logic            o_rclk,
    output logic [7:0]      o_read_addr_bus,
    output logic            o_rsel_n,
    output logic            o_rstb_n
);
    initial begin
        o_wclk   = 1'b0;
        o_rclk   = 1'b0;
        o_write_addr_bus  = 8'h00;
        o_read_addr_bus  = 8'h00;
        o_wdata  = 9'h000;
        o_wsel_n = 1'b1;
        o_wstb_n = 1'b1;
        o_rsel_n = 1'b1;
        o_rstb_n = 1'b1;
    end

    // One access on either or both ports; same edge on both gives a collision
    task automatic access(input logic w, input logic r, input logic [7:0] a,
                          input logic [8:0] d, input logic bs, input logic st);
        @(posedge i_clk_sys);
        if (w) begin
            o_write_addr_bus  <= a;
            o_wdata  <= d;
            o_wsel_n <= bs;
            o_wstb_n <= st;
        end
        if (r) begin
            o_read_addr_bus  <= a;
            o_rsel_n <= bs;
            o_rstb_n <= st;
        end
        @(posedge i_clk_sys);
        o_wclk <= w;
        o_rclk <= r;
        repeat (4) @(posedge i_clk_sys);
        o_wclk <= 1'b0;
        o_rclk <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
        // Released address and data lines show inverted values, never the stale word
        o_wsel_n <= 1'b1;
        o_wstb_n <= 1'b1;
        o_rsel_n <= 1'b1;
        o_rstb_n <= 1'b1;
        o_write_addr_bus  <= ~a;
        o_read_addr_bus  <= ~a;
        o_wdata  <= ~d;
    endtask
endmodule

// ### bench/tb_tpsram.sv
// Self-checking testbench for the two-port parity SRAM block
`timescale 1ns/1ps
module tb_tpsram;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       odd = 1'b0;
    logic       gen = 1'b0;
    logic       pipe = 1'b0;
    logic       wclk, rclk, wsel_n, wstb_n, rsel_n, rstb_n;
    logic [7:0] write_addr_bus, read_addr_bus;
    logic [8:0] wdata, rdata;
    logic       rerr, werr;
    int         mismatches = 0;
    int         total_checks = 0;

    tpsram i_tpsram (
        .i_clk_sys(clk), .i_rst(rst),
        .i_write_clock_in(wclk), .i_write_addr_bus(write_addr_bus),
        .i_write_block_sel_n(wsel_n), .i_write_strobe_n(wstb_n), .i_write_data_in(wdata),
        .i_read_clock_in(rclk), .i_read_addr_bus(read_addr_bus),
        .i_read_block_sel_n(rsel_n), .i_read_strobe_n(rstb_n),
        .i_parity_odd_sel(odd), .i_parity_generate(gen), .i_read_pipelined(pipe),
        .o_read_data_out(rdata), .o_read_parity_err(rerr), .o_write_parity_err(werr));

    tpsram_user i_tpsram_user (
        .i_clk_sys(clk), .o_wclk(wclk), .o_write_addr_bus(write_addr_bus), .o_wsel_n(wsel_n),
        .o_wstb_n(wstb_n), .o_wdata(wdata), .o_rclk(rclk), .o_read_addr_bus(read_addr_bus),
        .o_rsel_n(rsel_n), .o_rstb_n(rstb_n));

    initial begin
        forever #2.5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk_word(input logic [8:0] got, input logic [8:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD at %0t: word %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD at %0t: flag %b expected %b", $time, got, exp);
        end
    endtask

    task automatic set_mode(input logic o, input logic g, input logic p);
        @(posedge clk);
        odd  <= o;
        gen  <= g;
        pipe <= p;
        // Mode pins go through the synchronisers too
        repeat (4) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_check_mode;
        logic [8:0] d;
        for (int k = 0; k < 4; k++) begin
            set_mode(k[1], 1'b0, 1'b0);
            d = {k[0], 8'h5A ^ 8'(k)};
            i_tpsram_user.access(1'b1, 1'b0, 8'(k), d, 1'b0, 1'b0);
            chk_bit(werr, d[8] ^ (^d[7:0]) ^ k[1]);
            i_tpsram_user.access(1'b0, 1'b1, 8'(k), 9'h000, 1'b0, 1'b0);
            chk_word(rdata, d);
            chk_bit(rerr, d[8] ^ (^d[7:0]) ^ k[1]);
        end
        $display("test check_mode done");
    endtask

    task automatic t_generate;
        for (int k = 0; k < 2; k++) begin
            set_mode(k[0], 1'b1, 1'b0);
            i_tpsram_user.access(1'b1, 1'b0, 8'hF0, 9'h1C3, 1'b0, 1'b0);
            chk_bit(werr, 1'b0);
            i_tpsram_user.access(1'b0, 1'b1, 8'hF0, 9'h000, 1'b0, 1'b0);
            chk_word(rdata, {(^8'hC3) ^ k[0], 8'hC3});
            chk_bit(rerr, 1'b0);
        end
        $display("test generate done");
    endtask

    task automatic t_selects;
        set_mode(1'b0, 1'b1, 1'b0);
        i_tpsram_user.access(1'b1, 1'b0, 8'h20, 9'h011, 1'b0, 1'b0);
        i_tpsram_user.access(1'b1, 1'b0, 8'h20, 9'h022, 1'b1, 1'b0);
        i_tpsram_user.access(1'b1, 1'b0, 8'h20, 9'h033, 1'b0, 1'b1);
        i_tpsram_user.access(1'b1, 1'b0, 8'h21, 9'h044, 1'b0, 1'b0);
        i_tpsram_user.access(1'b0, 1'b1, 8'h20, 9'h000, 1'b0, 1'b0);
        chk_word(rdata, 9'h011);
        i_tpsram_user.access(1'b0, 1'b1, 8'h21, 9'h000, 1'b1, 1'b0);
        chk_word(rdata, 9'h011);
        i_tpsram_user.access(1'b0, 1'b1, 8'h21, 9'h000, 1'b0, 1'b1);
        chk_word(rdata, 9'h011);
        $display("test selects done");
    endtask

    task automatic t_pipelined;
        i_tpsram_user.access(1'b1, 1'b0, 8'h30, 9'h0AA, 1'b0, 1'b0);
        i_tpsram_user.access(1'b1, 1'b0, 8'h31, 9'h055, 1'b0, 1'b0);
        set_mode(1'b0, 1'b1, 1'b1);
        i_tpsram_user.access(1'b0, 1'b1, 8'h30, 9'h000, 1'b0, 1'b0);
        chk_word(rdata, 9'h011);
        i_tpsram_user.access(1'b0, 1'b1, 8'h31, 9'h000, 1'b0, 1'b0);
        chk_word(rdata, 9'h0AA);
        i_tpsram_user.access(1'b0, 1'b1, 8'h00, 9'h000, 1'b1, 1'b1);
        chk_word(rdata, 9'h055);
        // Odd parity check mode: an all-zero word is a parity error
        set_mode(1'b1, 1'b0, 1'b1);
        i_tpsram_user.access(1'b1, 1'b0, 8'h32, 9'h000, 1'b0, 1'b0);
        chk_bit(werr, 1'b1);
        i_tpsram_user.access(1'b0, 1'b1, 8'h32, 9'h000, 1'b0, 1'b0);
        chk_word(rdata, 9'h055);
        chk_bit(rerr, 1'b0);
        i_tpsram_user.access(1'b0, 1'b1, 8'h00, 9'h000, 1'b1, 1'b1);
        chk_word(rdata, 9'h000);
        chk_bit(rerr, 1'b1);
        $display("test pipelined done");
    endtask

    task automatic t_collision;
        set_mode(1'b0, 1'b1, 1'b0);
        i_tpsram_user.access(1'b1, 1'b0, 8'h40, 9'h0F0, 1'b0, 1'b0);
        i_tpsram_user.access(1'b1, 1'b1, 8'h40, 9'h00F, 1'b0, 1'b0);
        chk_word(rdata, 9'h00F);
        // Write well before the read edge: the new word is read
        i_tpsram_user.access(1'b1, 1'b0, 8'h41, 9'h1FF, 1'b0, 1'b0);
        i_tpsram_user.access(1'b0, 1'b1, 8'h41, 9'h000, 1'b0, 1'b0);
        chk_word(rdata, 9'h0FF);
        $display("test collision done");
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        // Whole run is about 300 cycles
        repeat (5000) @(posedge clk);
        mismatches++;
        close_out();
    end

    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_check_mode();
        t_generate();
        t_selects();
        t_pipelined();
        t_collision();
        close_out();
    end
endmodule
